// File: design/csdc_pkg.sv
package csdc_pkg;
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register byte offsets
  localparam logic [11:0] OFF_REQ = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_FREQ = 12'h008;
  localparam logic [11:0] OFF_FLAG = 12'h00C;
  localparam logic [11:0] OFF_IRQEN = 12'h010;
  localparam logic [11:0] OFF_DOZE = 12'h88C;

  // Request register fields
  localparam int REQ_DIV_LSB = 0;
  localparam int REQ_SRC_LSB = 4;
  localparam int REQ_CURDIV_LSB = 8;

  // Status register fields
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_NEW_SOURCE_READY_BIT = 3;
  localparam int STAT_OSC_READY_STATUS_BIT = 4;
  localparam int STAT_MF_OSC_READY_BIT = 5;
  localparam int STAT_HF_OSC_READY_BIT = 6;
  localparam int STAT_HOLD_BIT = 7;

  // Flag and enable bit
  localparam int FLAG_SWITCH_BIT = 0;

  // Doze register fields
  localparam int DOZE_RATIO_LSB = 0;
  localparam int DOZE_DOE_BIT = 4;
  localparam int DOZE_ROI_BIT = 5;
  localparam int DOZE_EN_BIT = 6;
  localparam int DOZE_IDLE_BIT = 7;
  localparam logic [7:0] DOZE_RST = 8'h00;

  // Widths and reset values
  localparam int SRC_N = 6;
  localparam int FRQ_W = 4;
  localparam logic [3:0] FRQ_RST = 4'h0;
  localparam logic [3:0] DIV_RST = 4'h0;

  // Clock source codes
  typedef enum logic [2:0] {
    SRC_EXT    = 3'b000,
    SRC_HF     = 3'b001,
    SRC_LF     = 3'b010,
    SRC_SEC    = 3'b011,
    SRC_EXTPLL = 3'b100,
    SRC_HFPLL  = 3'b101
  } csdc_src_t;

  // Source plus post-divider selection
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } csdc_clksel_t;

  // Switch sequencer states
  typedef enum logic [2:0] {
    SW_IDLE = 3'b000,
    SW_WAIT = 3'b001,
    SW_HELD = 3'b010,
    SW_GAP  = 3'b011,
    SW_LOAD = 3'b100
  } csdc_sw_t;
endpackage

// File: design/csdc_sync.sv
`timescale 1ns/1ps
module csdc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstSync_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // Three stages; output moves once stages two and three agree
      always_ff @(posedge core_clk or negedge rstSync_b)
      begin
        if (!rstSync_b)
        begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          dout[i] <= 1'b0;
        end
        else
        begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
          begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule

// File: design/csdc_top.sv
`timescale 1ns/1ps
module csdc_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] oscReady,
  input wire logic hfSettled,
  input wire logic isrEnter,
  input wire logic isrExit,
  input wire logic sleepExec,
  output csdc_pkg::csdc_clksel_t clkSel,
  output logic clkRun,
  output logic [5:0] oscEnable,
  output logic [3:0] freqSelect,
  output logic freqLoad,
  output logic mfClkHold,
  output logic switchIrq,
  output logic cpuRun,
  output logic enterIdle,
  output logic enterSleep
);
  logic rstMeta_b;
  logic rstSync_b;
  logic [5:0] readySync;
  logic [1:0] hfSync;
  logic awHave;
  logic wHave;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic wLane0;
  logic awTake;
  logic wTake;
  logic doWrite;
  logic arTake;
  logic next_awHave;
  logic next_wHave;
  logic next_bvalid;
  logic next_rvalid;
  logic wrReq;
  logic wrStat;
  logic wrFreq;
  logic wrFlag;
  logic wrIrqEn;
  logic wrDoze;
  csdc_pkg::csdc_clksel_t req;
  logic reqStart;
  logic hold;
  csdc_pkg::csdc_sw_t swState;
  logic newSrcReady;
  logic oscReadyStat;
  logic flagSet;
  logic switchFlag;
  logic irqEn;
  logic freqPending;
  logic hfSeenLow;
  logic idleSel;
  logic dozeEn;
  logic recoverOnIrq;
  logic reduceOnIrqExit;
  logic [2:0] dozeRatio;
  logic [7:0] dozeCnt;
  logic srcReadyNow;

  // Address decode shared by read and write paths
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == csdc_pkg::OFF_REQ) || (a == csdc_pkg::OFF_STAT) ||
               (a == csdc_pkg::OFF_FREQ) || (a == csdc_pkg::OFF_FLAG) ||
               (a == csdc_pkg::OFF_IRQEN) || (a == csdc_pkg::OFF_DOZE);
  endfunction

  // Doze counter mask: 2^(ratio+1)-1
  function automatic logic [7:0] dozeMask(input logic [2:0] r);
    logic [8:0] m;
    m = (9'h002 << r) - 9'h001;
    dozeMask = m[7:0];
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // Oscillator status pins into the core domain
  csdc_sync #(.W(8)) u_sync (
    .core_clk(core_clk),
    .rstSync_b(rstSync_b),
    .din({hfSettled, hfSettled, oscReady}),
    .dout({hfSync, readySync})
  );

  // AXI write channel handshakes
  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign doWrite = awHave && wHave && !s_axi_bvalid;
  assign next_awHave = doWrite ? 1'b0 : (awHave || awTake);
  assign next_wHave = doWrite ? 1'b0 : (wHave || wTake);
  assign next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wLane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= csdc_pkg::RESP_OKAY;
    end
    else
    begin
      awHave <= next_awHave;
      wHave <= next_wHave;
      s_axi_awready <= !next_awHave && !next_bvalid;
      s_axi_wready <= !next_wHave && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (awTake)
      begin
        awAddr <= s_axi_awaddr;
      end
      if (wTake)
      begin
        wData <= s_axi_wdata;
        wLane0 <= s_axi_wstrb[0];
      end
      if (doWrite)
      begin
        s_axi_bresp <= isMapped(awAddr) ? csdc_pkg::RESP_OKAY : csdc_pkg::RESP_DECERR;
      end
    end
  end

  // Register write strobes, low byte lane only
  assign wrReq = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_REQ);
  assign wrStat = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_STAT);
  assign wrFreq = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_FREQ);
  assign wrFlag = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_FLAG);
  assign wrIrqEn = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_IRQEN);
  assign wrDoze = doWrite && wLane0 && (awAddr == csdc_pkg::OFF_DOZE);

  // AXI read channel, data captured with the address
  assign arTake = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = arTake || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= csdc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (arTake)
      begin
        s_axi_rresp <= isMapped(s_axi_araddr) ? csdc_pkg::RESP_OKAY : csdc_pkg::RESP_DECERR;
        s_axi_rdata <= 32'h0000_0000;
        unique case (s_axi_araddr)
          csdc_pkg::OFF_REQ:
          begin
            s_axi_rdata[csdc_pkg::REQ_DIV_LSB +: 4] <= req.div;
            s_axi_rdata[csdc_pkg::REQ_SRC_LSB +: 3] <= req.src;
            s_axi_rdata[csdc_pkg::REQ_CURDIV_LSB +: 4] <= clkSel.div;
          end
          csdc_pkg::OFF_STAT:
          begin
            s_axi_rdata[csdc_pkg::STAT_SRC_LSB +: 3] <= clkSel.src;
            s_axi_rdata[csdc_pkg::STAT_NEW_SOURCE_READY_BIT] <= newSrcReady;
            s_axi_rdata[csdc_pkg::STAT_OSC_READY_STATUS_BIT] <= oscReadyStat;
            s_axi_rdata[csdc_pkg::STAT_MF_OSC_READY_BIT] <= !freqPending && readySync[csdc_pkg::SRC_HF];
            s_axi_rdata[csdc_pkg::STAT_HF_OSC_READY_BIT] <= !freqPending && readySync[csdc_pkg::SRC_HF];
            s_axi_rdata[csdc_pkg::STAT_HOLD_BIT] <= hold;
          end
          csdc_pkg::OFF_FREQ: s_axi_rdata[csdc_pkg::FRQ_W-1:0] <= freqSelect;
          csdc_pkg::OFF_FLAG: s_axi_rdata[csdc_pkg::FLAG_SWITCH_BIT] <= switchFlag;
          csdc_pkg::OFF_IRQEN: s_axi_rdata[csdc_pkg::FLAG_SWITCH_BIT] <= irqEn;
          csdc_pkg::OFF_DOZE:
          begin
            s_axi_rdata[csdc_pkg::DOZE_RATIO_LSB +: 3] <= dozeRatio;
            s_axi_rdata[csdc_pkg::DOZE_DOE_BIT] <= reduceOnIrqExit;
            s_axi_rdata[csdc_pkg::DOZE_ROI_BIT] <= recoverOnIrq;
            s_axi_rdata[csdc_pkg::DOZE_EN_BIT] <= dozeEn;
            s_axi_rdata[csdc_pkg::DOZE_IDLE_BIT] <= idleSel;
          end
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Request and hold registers; codes above the six sources are ignored
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      req <= '{src: csdc_pkg::SRC_HF, div: csdc_pkg::DIV_RST};
      reqStart <= 1'b0;
      hold <= 1'b0;
    end
    else
    begin
      reqStart <= 1'b0;
      if (wrReq && (wData[csdc_pkg::REQ_SRC_LSB +: 3] <= csdc_pkg::SRC_HFPLL))
      begin
        req.src <= wData[csdc_pkg::REQ_SRC_LSB +: 3];
        req.div <= wData[csdc_pkg::REQ_DIV_LSB +: 4];
        reqStart <= 1'b1;
      end
      if (wrStat)
      begin
        hold <= wData[csdc_pkg::STAT_HOLD_BIT];
      end
    end
  end

  // Requested source ready: already running counts as ready
  assign srcReadyNow = (req.src == clkSel.src) || readySync[req.src];

  // Switch sequencer, runs every core cycle regardless of doze
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      swState <= csdc_pkg::SW_IDLE;
      clkSel <= '{src: csdc_pkg::SRC_HF, div: csdc_pkg::DIV_RST};
      clkRun <= 1'b1;
      newSrcReady <= 1'b0;
      flagSet <= 1'b0;
    end
    else
    begin
      flagSet <= 1'b0;
      unique case (swState)
        csdc_pkg::SW_IDLE:
        begin
          if (reqStart)
          begin
            swState <= csdc_pkg::SW_WAIT;
          end
        end
        csdc_pkg::SW_WAIT:
        begin
          if (srcReadyNow && !reqStart)
          begin
            newSrcReady <= 1'b1;
            flagSet <= 1'b1;
            swState <= hold ? csdc_pkg::SW_HELD : csdc_pkg::SW_GAP;
          end
        end
        csdc_pkg::SW_HELD:
        begin
          if (req == clkSel)
          begin
            newSrcReady <= 1'b0;
            swState <= csdc_pkg::SW_IDLE;
          end
          else if (reqStart)
          begin
            newSrcReady <= 1'b0;
            swState <= csdc_pkg::SW_WAIT;
          end
          else if (!hold)
          begin
            swState <= csdc_pkg::SW_GAP;
          end
        end
        csdc_pkg::SW_GAP:
        begin
          clkRun <= 1'b0;
          swState <= csdc_pkg::SW_LOAD;
        end
        csdc_pkg::SW_LOAD:
        begin
          clkSel <= req;
          clkRun <= 1'b1;
          newSrcReady <= 1'b0;
          swState <= reqStart ? csdc_pkg::SW_WAIT : csdc_pkg::SW_IDLE;
        end
        default: swState <= csdc_pkg::SW_IDLE;
      endcase
    end
  end

  // Pollable ready, oscillator enables and interrupt flag
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      oscReadyStat <= 1'b0;
      oscEnable <= 6'h02;
      switchFlag <= 1'b0;
      irqEn <= 1'b0;
      switchIrq <= 1'b0;
    end
    else
    begin
      oscReadyStat <= newSrcReady || ((swState == csdc_pkg::SW_IDLE) && !reqStart);
      oscEnable <= (6'h01 << clkSel.src) | (6'h01 << req.src);
      if (wrIrqEn)
      begin
        irqEn <= wData[csdc_pkg::FLAG_SWITCH_BIT];
      end
      // Write one clears; a same-cycle set wins
      if (flagSet)
      begin
        switchFlag <= 1'b1;
      end
      else if (wrFlag && wData[csdc_pkg::FLAG_SWITCH_BIT])
      begin
        switchFlag <= 1'b0;
      end
      switchIrq <= (switchFlag || flagSet) && irqEn;
    end
  end

  // Internal frequency select and retune pending tracking
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      freqSelect <= csdc_pkg::FRQ_RST;
      freqLoad <= 1'b0;
      freqPending <= 1'b0;
      hfSeenLow <= 1'b0;
      mfClkHold <= 1'b0;
    end
    else
    begin
      freqLoad <= wrFreq;
      if (wrFreq)
      begin
        freqSelect <= wData[csdc_pkg::FRQ_W-1:0];
        freqPending <= 1'b1;
        hfSeenLow <= 1'b0;
      end
      else if (freqPending && !hfSync[0])
      begin
        hfSeenLow <= 1'b1;
      end
      else if (freqPending && hfSeenLow && hfSync[1])
      begin
        freqPending <= 1'b0;
      end
      mfClkHold <= wrFreq || (freqPending && !(hfSeenLow && hfSync[1]));
    end
  end

  // Doze and idle control with ISR hooks
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      idleSel <= csdc_pkg::DOZE_RST[csdc_pkg::DOZE_IDLE_BIT];
      dozeEn <= csdc_pkg::DOZE_RST[csdc_pkg::DOZE_EN_BIT];
      recoverOnIrq <= csdc_pkg::DOZE_RST[csdc_pkg::DOZE_ROI_BIT];
      reduceOnIrqExit <= csdc_pkg::DOZE_RST[csdc_pkg::DOZE_DOE_BIT];
      dozeRatio <= csdc_pkg::DOZE_RST[csdc_pkg::DOZE_RATIO_LSB +: 3];
    end
    else
    begin
      if (wrDoze)
      begin
        idleSel <= wData[csdc_pkg::DOZE_IDLE_BIT];
        dozeEn <= wData[csdc_pkg::DOZE_EN_BIT];
        recoverOnIrq <= wData[csdc_pkg::DOZE_ROI_BIT];
        reduceOnIrqExit <= wData[csdc_pkg::DOZE_DOE_BIT];
        dozeRatio <= wData[csdc_pkg::DOZE_RATIO_LSB +: 3];
      end
      // Hardware updates override a same-cycle write
      if (isrEnter && recoverOnIrq)
      begin
        dozeEn <= 1'b0;
      end
      else if (isrExit && reduceOnIrqExit)
      begin
        dozeEn <= 1'b1;
      end
    end
  end

  // CPU cycle enable: one in 2^(ratio+1) cycles while dozing
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      dozeCnt <= 8'h00;
      cpuRun <= 1'b0;
    end
    else
    begin
      dozeCnt <= dozeCnt + 8'h01;
      cpuRun <= !dozeEn || ((dozeCnt & dozeMask(dozeRatio)) == dozeMask(dozeRatio));
    end
  end

  // Sleep instruction dispatch, not blocked by a pending switch
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      enterIdle <= 1'b0;
      enterSleep <= 1'b0;
    end
    else
    begin
      enterIdle <= sleepExec && idleSel;
      enterSleep <= sleepExec && !idleSel;
    end
  end
endmodule

// File: tb/csdc_osc_model.sv
`timescale 1ns/1ps
module csdc_osc_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic [5:0] oscEnable,
  input wire logic freqLoad,
  output logic [5:0] oscReady,
  output logic hfSettled
);
  int cnt [6] = '{default: 0};
  int hfCnt = 0;
  initial oscReady = 6'h00;
  initial hfSettled = 1'b1;
  // Source reports ready only after its start-up time while enabled
  always @(posedge core_clk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      cnt[i] <= oscEnable[i] ? cnt[i] + 1 : 0;
      oscReady[i] <= oscEnable[i] && cnt[i] >= (slow ? 40 : 3);
    end
  end
  // Retune drops settled for a while, then restores it
  always @(posedge core_clk)
  begin
    hfCnt <= freqLoad ? 12 : (hfCnt > 0 ? hfCnt - 1 : 0);
    hfSettled <= !(freqLoad || hfCnt > 0);
  end
endmodule

// File: tb/csdc_top_assertions.sv
`timescale 1ns/1ps
module csdc_top_assertions (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic sleepExec,
  input wire csdc_pkg::csdc_clksel_t clkSel,
  input wire logic clkRun,
  input wire logic [5:0] oscEnable,
  input wire logic freqLoad,
  input wire logic mfClkHold,
  input wire logic enterIdle,
  input wire logic enterSleep
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Switch gap and clock hand-over
  gap_one_cycle_a: assert property ($fell(clkRun) |=> clkRun)
    else $error("clock gap longer than one cycle");
  sel_after_gap_a: assert property (!$stable(clkSel) |-> !$past(clkRun))
    else $error("selection changed without a gap");
  sel_osc_on_a: assert property (oscEnable[clkSel.src])
    else $error("selected source not enabled");
  // Sleep instruction outcome and retune hold
  sleep_pick_a: assert property (sleepExec |=> enterIdle ^ enterSleep)
    else $error("sleep gave no single mode");
  sleep_cause_a: assert property ((enterIdle || enterSleep) |-> $past(sleepExec))
    else $error("mode entry without sleep");
  freq_hold_a: assert property (freqLoad |-> ##[0:1] mfClkHold)
    else $error("mid clock not held on retune");
  // Read answers
  read_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("decode error data not zero");
  cover property ($fell(clkRun));
  cover property (enterIdle);
  cover property (freqLoad);
endmodule
bind csdc_top csdc_top_assertions i_csdc_top_assertions (.core_clk(core_clk), .rst_b(rst_b),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .sleepExec(sleepExec),
  .clkSel(clkSel), .clkRun(clkRun), .oscEnable(oscEnable), .freqLoad(freqLoad),
  .mfClkHold(mfClkHold), .enterIdle(enterIdle), .enterSleep(enterSleep));

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = 32'h0;
  logic [3:0] wStrb = 4'hF;
  logic isrEnter = 1'b0, isrExit = 1'b0, sleepExec = 1'b0, slow = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, hfSettled, clkRun, freqLoad;
  logic mfClkHold, switchIrq, cpuRun, enterIdle, enterSleep;
  logic [1:0] bResp, rResp, rs;
  logic [31:0] rData, rv;
  logic [5:0] oscReady, oscEnable;
  logic [3:0] freqSelect;
  csdc_pkg::csdc_clksel_t clkSel;
  int errors = 0;
  int nCompared = 0;
  // Clock
  initial forever #2 core_clk = ~core_clk;
  csdc_top i_csdc_top (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .oscReady(oscReady), .hfSettled(hfSettled), .isrEnter(isrEnter),
    .isrExit(isrExit), .sleepExec(sleepExec), .clkSel(clkSel), .clkRun(clkRun),
    .oscEnable(oscEnable), .freqSelect(freqSelect), .freqLoad(freqLoad),
    .mfClkHold(mfClkHold), .switchIrq(switchIrq), .cpuRun(cpuRun), .enterIdle(enterIdle),
    .enterSleep(enterSleep));
  csdc_osc_model i_csdc_osc_model (.core_clk(core_clk), .slow(slow), .oscEnable(oscEnable),
    .freqLoad(freqLoad), .oscReady(oscReady), .hfSettled(hfSettled));
  // Verdict and end of run
  task automatic report_and_stop();
    if (errors == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One clock edge with a bound on the wait
  task automatic guard(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 3000)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  // Bus write and read cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      guard(n);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end
    while (!bValid);
    rs = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    int n = 0;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
    begin
      guard(n);
      if (arReady) arValid <= 1'b0;
    end
    while (!rValid);
    rv = rData;
    rs = rResp;
    rReady <= 1'b0;
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    wr(a, d, 4'hF);
    chk("bresp", 32'(rs), 32'h0);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    rd(a);
    chk(nm, rv & m, e);
  endtask
  task automatic waitSel(input logic [6:0] e, output int n);
    n = 0;
    while (clkSel !== e) guard(n);
    chk("clkSel", 32'(clkSel), 32'(e));
  endtask
  task automatic pollNoscr();
    int n = 0;
    do
    begin
      rd(csdc_pkg::OFF_STAT);
      n++;
    end
    while (!rv[3] && n < 200);
    if (!rv[3])
    begin
      errors++;
      report_and_stop();
    end
  endtask
  // One-cycle core pulse: 0 isr entry, 1 isr exit, 2 sleep
  task automatic pulse(input int k);
    @(posedge core_clk);
    isrEnter <= k == 0;
    isrExit <= k == 1;
    sleepExec <= k == 2;
    @(posedge core_clk);
    isrEnter <= 1'b0;
    isrExit <= 1'b0;
    sleepExec <= 1'b0;
    #1;
  endtask
  // Main sequence
  initial
  begin
    logic [3:0] dv;
    logic [6:0] prev;
    int k, n;
    void'($urandom(13703));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
    rc("doze rst", csdc_pkg::OFF_DOZE, 32'hFF, 32'h00);
    rc("req rst", csdc_pkg::OFF_REQ, 32'h7F, 32'h10);
    rd(12'h020);
    chk("unmapped", 32'(rs), 32'h3);
    wr(12'h020, 32'h0, 4'hF);
    chk("unmapped wr", 32'(rs), 32'h3);
    wr(csdc_pkg::OFF_DOZE, 32'hFF, 4'h0);
    rc("no strobe", csdc_pkg::OFF_DOZE, 32'hFF, 32'h00);
    // Every source with a random divider, interrupt masked once
    for (int s = 0; s < 6; s++)
    begin
      dv = 4'($urandom);
      prev = clkSel;
      slow <= s[0];
      w(csdc_pkg::OFF_IRQEN, 32'(s != 3));
      w(csdc_pkg::OFF_REQ, 32'({s[2:0], dv}));
      repeat (10) @(posedge core_clk);
      if (s[0]) chk("old kept", 32'(clkSel), 32'(prev));
      waitSel({s[2:0], dv}, n);
      repeat (2) @(posedge core_clk);
      chk("irq", 32'(switchIrq), 32'(s != 3));
      rc("flag", csdc_pkg::OFF_FLAG, 32'h1, 32'h1);
      rc("cur div", csdc_pkg::OFF_REQ, 32'hF00, 32'(dv) << 8);
      w(csdc_pkg::OFF_FLAG, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq clr", 32'(switchIrq), 32'h0);
    end
    w(csdc_pkg::OFF_REQ, 32'h6F);
    rc("bad src", csdc_pkg::OFF_REQ, 32'h7F, 32'({3'h5, dv}));
    // Divider-only change while in doze at 1:256
    w(csdc_pkg::OFF_DOZE, 32'h47);
    w(csdc_pkg::OFF_REQ, 32'h53);
    waitSel(7'h53, n);
    chk("fast", 32'(n < 8), 32'h1);
    // Each ratio code gives one CPU cycle per 2 to the code plus one
    for (int r = 0; r < 9; r++)
    begin
      w(csdc_pkg::OFF_DOZE, r < 8 ? 32'h40 | 32'(r) : 32'h0);
      repeat (3) @(posedge core_clk);
      k = 0;
      repeat (r < 8 ? 4 << (r + 1) : 8)
      begin
        @(posedge core_clk);
        k += 32'(cpuRun);
      end
      chk("cpu cycles", 32'(k), r < 8 ? 32'h4 : 32'h8);
    end
    // Interrupt entry and exit move the doze enable
    w(csdc_pkg::OFF_DOZE, 32'h60);
    pulse(0);
    rc("roi", csdc_pkg::OFF_DOZE, 32'h40, 32'h0);
    pulse(1);
    rc("no doe", csdc_pkg::OFF_DOZE, 32'h40, 32'h0);
    w(csdc_pkg::OFF_DOZE, 32'h10);
    pulse(1);
    rc("doe", csdc_pkg::OFF_DOZE, 32'h40, 32'h40);
    pulse(0);
    rc("no roi", csdc_pkg::OFF_DOZE, 32'h40, 32'h40);
    w(csdc_pkg::OFF_DOZE, 32'h80);
    pulse(2);
    chk("idle", 32'({enterIdle, enterSleep}), 32'h2);
    // Held switch, sleep while waiting, then release
    slow <= 1'b1;
    w(csdc_pkg::OFF_DOZE, 32'h0);
    w(csdc_pkg::OFF_STAT, 32'h80);
    w(csdc_pkg::OFF_REQ, 32'h20);
    pulse(2);
    chk("sleep", 32'({enterIdle, enterSleep}), 32'h1);
    pollNoscr();
    chk("new_source_ready", 32'(rv[3]), 32'h1);
    repeat (20) @(posedge core_clk);
    chk("held", 32'(clkSel), 32'h53);
    rc("osc_ready_status", csdc_pkg::OFF_STAT, 32'h18, 32'h18);
    w(csdc_pkg::OFF_STAT, 32'h0);
    waitSel(7'h20, n);
    // Held switch abandoned by requesting the current selection
    w(csdc_pkg::OFF_STAT, 32'h80);
    w(csdc_pkg::OFF_REQ, 32'h07);
    pollNoscr();
    w(csdc_pkg::OFF_REQ, 32'h20);
    repeat (20) @(posedge core_clk);
    chk("abandon", 32'(clkSel), 32'h20);
    rc("abandon rdy", csdc_pkg::OFF_STAT, 32'h8, 32'h0);
    // Back onto the high-frequency source so its ready can return
    w(csdc_pkg::OFF_STAT, 32'h0);
    w(csdc_pkg::OFF_REQ, 32'h10);
    waitSel(7'h10, n);
    // Frequency retune clears ready bits until settled
    dv = 4'($urandom);
    w(csdc_pkg::OFF_FREQ, 32'(dv));
    rc("hf lost", csdc_pkg::OFF_STAT, 32'h60, 32'h0);
    chk("freq", 32'(freqSelect), 32'(dv));
    chk("mf hold", 32'(mfClkHold), 32'h1);
    n = 0;
    do
    begin
      rd(csdc_pkg::OFF_STAT);
      n++;
    end
    while (!rv[6] && n < 100);
    if (!rv[6])
    begin
      errors++;
      report_and_stop();
    end
    chk("hf back", rv & 32'h60, 32'h60);
    chk("mf free", 32'(mfClkHold), 32'h0);
    report_and_stop();
  end
endmodule
